/* rtl/interval_timer_pkg.sv */
// Constants and types for the power gating interval timer
package interval_timer_pkg;

  localparam int CLK_FREQ_HZ  = 10_000_000;
  localparam int MS_PER_S     = 1000;
  // Cycles of sys_clk in one millisecond tick of the time base
  localparam int MS_CYCLES    = CLK_FREQ_HZ / MS_PER_S;
  localparam int PRE_W        = 14;

  // Interval code: one step of the code is CODE_STEP_MS
  localparam int CODE_W       = 17;
  localparam int MS_W         = 24;
  localparam logic [MS_W-1:0] CODE_STEP_MS = 24'h000064;

  // Times in milliseconds, all counted in ticks of the time base
  localparam logic [MS_W-1:0] TAIL_MS    = 24'h000032;
  localparam logic [6:0]      MEAS_MS    = 7'h64;
  localparam logic [4:0]      VALID_MS   = 5'h14;
  localparam logic [4:0]      WINDOW_MS  = 5'h1e;
  localparam logic [4:0]      RELEASE_MS = 5'h14;

  typedef enum logic [1:0]
  {
    ST_MEASURE = 2'h0,
    ST_RUN     = 2'h1,
    ST_IDLE    = 2'h3
  } phase_t;

  typedef struct packed
  {
    logic [1:0]       doneSync;
    logic             donePrev;
    logic [1:0]       manSync;
    logic [1:0]       modeSync;
    logic [PRE_W-1:0] preCnt;
    phase_t           phase;
    logic [6:0]       measCnt;
    logic             measOn;
    logic             periodic;
    logic [MS_W-1:0]  periodMs;
    logic [MS_W-1:0]  cnt;
    logic             enable;
    logic             doneSeen;
    logic             manOn;
    logic             manHeld;
    logic [4:0]       winCnt;
    logic [4:0]       hiCnt;
    logic [4:0]       lowCnt;
  } state_t;

endpackage : interval_timer_pkg

/* rtl/power_gating_interval_timer.sv */
// Power gating interval timer with manual power-on and one-shot mode
`timescale 1ns/1ps

module power_gating_interval_timer
  import interval_timer_pkg::*;
#(
  parameter int MS_TICK = MS_CYCLES
)
(
  input  wire logic              sys_clk,
  input  wire logic              sys_rst,
  input  wire logic              clkEn,
  input  wire logic              doneIn,
  input  wire logic              manualPinIn,
  input  wire logic              modeSelIn,
  input  wire logic [CODE_W-1:0] intervalCode,
  output      logic              regulatorEnableOut,
  output      logic              measureActive
);

  state_t          cur_ff;
  state_t          nxt_ff;
  logic            tick;
  logic            doneRise;
  logic            manLvl;
  logic            manValid;
  logic            manRelease;
  logic [MS_W-1:0] maxWidth;

  // Code 0 is not a legal reading; treat it as the shortest interval
  function automatic logic [MS_W-1:0] msOfCode(
    input logic [CODE_W-1:0] code
  );
    logic [MS_W-1:0] steps;
    steps = {{(MS_W-CODE_W){1'b0}}, code};
    if (steps == '0)
    begin
      steps = 24'h000001;
    end
    return MS_W'(steps * CODE_STEP_MS);
  endfunction : msOfCode

  always_comb
  begin
    nxt_ff     = cur_ff;
    manValid   = 1'b0;
    manRelease = 1'b0;
    // Done, manual and mode pins pass two flops before any logic looks at them
    nxt_ff.doneSync = {cur_ff.doneSync[0], doneIn};
    nxt_ff.manSync  = {cur_ff.manSync[0], manualPinIn};
    nxt_ff.modeSync = {cur_ff.modeSync[0], modeSelIn};
    nxt_ff.donePrev = cur_ff.doneSync[1];
    doneRise = cur_ff.doneSync[1] & ~cur_ff.donePrev;
    manLvl   = cur_ff.manSync[1];
    maxWidth = cur_ff.periodMs - TAIL_MS;

    // Millisecond time base
    tick = (cur_ff.preCnt == PRE_W'(MS_TICK - 1));
    if (tick)
    begin
      nxt_ff.preCnt = '0;
    end
    else
    begin
      nxt_ff.preCnt = cur_ff.preCnt + 1'b1;
    end

    // Manual request filter, debounced on both edges
    if (tick)
    begin
      if (cur_ff.manOn)
      begin
        if (manLvl)
        begin
          nxt_ff.lowCnt = '0;
        end
        else if (cur_ff.lowCnt == RELEASE_MS - 5'h01)
        begin
          nxt_ff.lowCnt = '0;
          nxt_ff.manOn  = 1'b0;
          manRelease    = 1'b1;
        end
        else
        begin
          nxt_ff.lowCnt = cur_ff.lowCnt + 1'b1;
        end
      end
      else if (manLvl || (cur_ff.winCnt != '0))
      begin
        nxt_ff.winCnt = cur_ff.winCnt + 1'b1;
        nxt_ff.hiCnt  = cur_ff.hiCnt + {4'h0, manLvl};
        if (manLvl && (cur_ff.hiCnt == VALID_MS - 5'h01))
        begin
          manValid      = 1'b1;
          nxt_ff.manOn  = 1'b1;
          nxt_ff.winCnt = '0;
          nxt_ff.hiCnt  = '0;
        end
        else if (cur_ff.winCnt == WINDOW_MS - 5'h01)
        begin
          nxt_ff.winCnt = '0;
          nxt_ff.hiCnt  = '0;
        end
      end
    end

    unique case (cur_ff.phase)
      ST_MEASURE:
      begin
        // Manual activity holds the reading at its start
        if (manLvl || cur_ff.manOn)
        begin
          nxt_ff.measCnt = '0;
        end
        else if (tick)
        begin
          if (cur_ff.measCnt == MEAS_MS - 7'h01)
          begin
            nxt_ff.phase    = ST_RUN;
            nxt_ff.measOn   = 1'b0;
            nxt_ff.periodMs = msOfCode(intervalCode);
            nxt_ff.periodic = cur_ff.modeSync[1];
            nxt_ff.enable   = 1'b1;
            nxt_ff.cnt      = '0;
            nxt_ff.doneSeen = 1'b0;
          end
          else
          begin
            nxt_ff.measCnt = cur_ff.measCnt + 1'b1;
          end
        end
      end
      ST_RUN:
      begin
        if (cur_ff.manHeld)
        begin
          // The interval count stays cleared until the pin is released
          nxt_ff.cnt = '0;
          if (manRelease)
          begin
            nxt_ff.manHeld = 1'b0;
          end
        end
        else
        begin
          if (doneRise)
          begin
            nxt_ff.doneSeen = 1'b1;
            if (!cur_ff.doneSeen)
            begin
              nxt_ff.enable = 1'b0;
            end
          end
          if (tick)
          begin
            if (cur_ff.cnt == maxWidth - 1'b1)
            begin
              nxt_ff.enable = 1'b0;
            end
            if (cur_ff.cnt == cur_ff.periodMs - 1'b1)
            begin
              nxt_ff.cnt      = '0;
              nxt_ff.doneSeen = 1'b0;
              if (cur_ff.periodic)
              begin
                nxt_ff.enable = 1'b1;
              end
              else
              begin
                nxt_ff.phase  = ST_IDLE;
                nxt_ff.enable = 1'b0;
              end
            end
            else
            begin
              nxt_ff.cnt = cur_ff.cnt + 1'b1;
            end
          end
        end
        // Request honoured only while the enable is low
        if (manValid && !cur_ff.enable)
        begin
          // Overrides a one-shot end in this cycle, else idle would hold it low
          nxt_ff.phase    = ST_RUN;
          nxt_ff.enable   = 1'b1;
          nxt_ff.manHeld  = 1'b1;
          nxt_ff.cnt      = '0;
          nxt_ff.doneSeen = 1'b0;
        end
      end
      ST_IDLE:
      begin
        if (manValid)
        begin
          nxt_ff.phase    = ST_RUN;
          nxt_ff.enable   = 1'b1;
          nxt_ff.manHeld  = 1'b1;
          nxt_ff.cnt      = '0;
          nxt_ff.doneSeen = 1'b0;
        end
      end
      default:
      begin
        // Corrupted phase code: take a fresh reading
        nxt_ff.phase   = ST_MEASURE;
        nxt_ff.measOn  = 1'b1;
        nxt_ff.measCnt = '0;
        nxt_ff.enable  = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      cur_ff        <= '0;
      cur_ff.measOn <= 1'b1;
    end
    else if (clkEn)
    begin
      cur_ff <= nxt_ff;
    end
  end

  assign regulatorEnableOut = cur_ff.enable;
  assign measureActive      = cur_ff.measOn;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);

  a_meas_no_pulse: assert property (
    cur_ff.phase == ST_MEASURE |-> !regulatorEnableOut)
    else $error("enable high during the reading");

  a_meas_abort: assert property (
    (cur_ff.phase == ST_MEASURE && manLvl && clkEn)
      |=> cur_ff.measCnt == '0)
    else $error("reading not restarted by manual request");

  a_done_drop: assert property (
    (cur_ff.phase == ST_RUN && cur_ff.enable && doneRise
      && !cur_ff.doneSeen && !cur_ff.manHeld && !manValid && clkEn)
      |=> !regulatorEnableOut && cur_ff.doneSeen)
    else $error("first completion did not drop enable");

  a_tail_low: assert property (
    (cur_ff.phase == ST_RUN && !cur_ff.manHeld
      && cur_ff.cnt >= maxWidth) |-> !regulatorEnableOut)
    else $error("enable high in the interval tail");

  a_period_edge: assert property (
    (cur_ff.phase == ST_RUN && cur_ff.periodic && !cur_ff.manHeld
      && tick && clkEn && cur_ff.cnt == cur_ff.periodMs - 1'b1)
      |=> regulatorEnableOut && cur_ff.cnt == '0)
    else $error("periodic pulse not restarted on interval end");

  a_oneshot_idle: assert property (
    (cur_ff.phase == ST_RUN && !cur_ff.periodic && !cur_ff.manHeld
      && !manValid && tick && clkEn
      && cur_ff.cnt == cur_ff.periodMs - 1'b1)
      |=> cur_ff.phase == ST_IDLE && !regulatorEnableOut)
    else $error("one-shot pulse did not end in idle");

  a_manual_ignored: assert property (
    (cur_ff.enable && !cur_ff.manHeld && manValid && clkEn)
      |=> !cur_ff.manHeld)
    else $error("manual request taken while enable high");

  a_manual_start: assert property (
    (cur_ff.phase != ST_MEASURE && !cur_ff.enable && manValid && clkEn)
      |=> regulatorEnableOut && cur_ff.manHeld && cur_ff.cnt == '0)
    else $error("manual request did not raise enable");

  a_held_on: assert property (
    (cur_ff.manHeld && doneRise && clkEn)
      |=> regulatorEnableOut && cur_ff.cnt == '0)
    else $error("completion acted on while manual pin held");

  a_mode_latch: assert property (
    (cur_ff.phase == ST_MEASURE && clkEn) ##1 cur_ff.phase == ST_RUN
      |-> cur_ff.periodic == $past(cur_ff.modeSync[1]))
    else $error("mode not taken from strap");

  c_done_early: cover property (
    cur_ff.enable && doneRise && !cur_ff.doneSeen ##1 !cur_ff.enable);
  c_full_width: cover property (
    cur_ff.enable ##1 !cur_ff.enable && cur_ff.cnt >= maxWidth);
  c_manual_pulse: cover property (
    cur_ff.phase == ST_IDLE && manValid ##1 cur_ff.manHeld);

endmodule : power_gating_interval_timer

/* verif/done_responder.sv */
// Behavioural microcontroller that answers each enable pulse with completion
`timescale 1ns/1ps
module done_responder
(
  input  wire logic       sys_clk,
  input  wire logic       enableIn,
  input  wire logic       replyOn,
  input  wire logic       replyTwice,
  input  wire logic [7:0] replyDelay,
  output      logic       doneOut
);
  initial doneOut = 1'b0;

  // Pulse held three cycles, well past the shortest the timer accepts
  task automatic send_pulse;
    #1 doneOut = 1'b1;
    repeat (3) @(posedge sys_clk);
    #1 doneOut = 1'b0;
  endtask : send_pulse

  initial
  forever
  begin
    @(posedge enableIn);
    if (replyOn)
    begin
      repeat (replyDelay) @(posedge sys_clk);
      send_pulse();
      // Extra edge in the same interval, which must have no effect
      if (replyTwice)
      begin
        repeat (4) @(posedge sys_clk);
        send_pulse();
      end
    end
  end
endmodule : done_responder

/* verif/power_gating_interval_timer_bench.sv */
// Self-checking bench for the power gating interval timer
`timescale 1ns/1ps
module power_gating_interval_timer_bench;
  import interval_timer_pkg::*;
  localparam int TICK = 4;
  logic              sys_clk = 1'b0;
  logic              sys_rst = 1'b1;
  logic              clkEn = 1'b1;
  logic              manualPinIn = 1'b0;
  logic              modeSelIn = 1'b1;
  logic [CODE_W-1:0] intervalCode = 17'h00001;
  logic              doneIn;
  logic              regulatorEnableOut;
  logic              measureActive;
  logic              replyOn = 1'b0;
  logic              replyTwice = 1'b0;
  logic [7:0]        replyDelay = 8'h10;
  int                mismatches = 0;
  int                compares = 0;
  int                n, w, l, d, code;

  always #50 sys_clk = ~sys_clk;

  power_gating_interval_timer #(.MS_TICK(TICK)) dut
  (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .clkEn(clkEn),
    .doneIn(doneIn), .manualPinIn(manualPinIn), .modeSelIn(modeSelIn),
    .intervalCode(intervalCode), .regulatorEnableOut(regulatorEnableOut),
    .measureActive(measureActive)
  );

  done_responder partner
  (
    .sys_clk(sys_clk), .enableIn(regulatorEnableOut), .replyOn(replyOn),
    .replyTwice(replyTwice), .replyDelay(replyDelay), .doneOut(doneIn)
  );

  task complete_run;
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : complete_run

  task check(input bit ok, input string msg);
    compares++;
    if (!ok)
    begin
      mismatches++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask : check

  function automatic int width_max(input int c);
    return (c * 100 - 50) * TICK;
  endfunction : width_max

  function automatic bit near(input int v, input int e);
    return (v >= e - 2) && (v <= e + 2);
  endfunction : near

  task step(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask : step

  task wait_en(input logic v, input int bound, output int cyc);
    cyc = 0;
    while (regulatorEnableOut !== v)
    begin
      step(1);
      cyc++;
      if (cyc > bound)
      begin
        check(1'b0, "enable wait timed out");
        complete_run();
      end
    end
  endtask : wait_en

  // Reset, optional manual press during the reading, then the first rise
  task start(input logic mode, input int c, input bit press);
    sys_rst = 1'b1;
    modeSelIn = mode;
    intervalCode = CODE_W'(c);
    step(8);
    check(regulatorEnableOut === 1'b0 && measureActive === 1'b1,
          "reset");
    sys_rst = 1'b0;
    if (press)
    begin
      step(100);
      manualPinIn = 1'b1;
      step(200);
      check(measureActive === 1'b1, "reading ended under press");
      check(regulatorEnableOut === 1'b0, "enable under press");
      manualPinIn = 1'b0;
    end
    wait_en(1'b1, 160 * TICK, n);
    check(n >= 100 * TICK - 4, "reading too short");
    check(measureActive === 1'b0, "reading flag at rise");
  endtask : start

  // One periodic pulse from its rising edge to the next rising edge
  task pulse_len(output int hi, output int lo);
    wait_en(1'b0, 3000 * TICK, hi);
    wait_en(1'b1, 3000 * TICK, lo);
  endtask : pulse_len

  initial
  begin
    void'($urandom(96544));
    code = $urandom_range(3, 2);
    start(1'b1, code, 1'b1);
    repeat (2)
    begin
      pulse_len(w, l);
      check(near(w, width_max(code)), "width");
      check(l >= 50 * TICK - 2 && l <= 50 * TICK + 2, "tail");
      check(w + l == code * 100 * TICK, "period");
    end
    replyOn = 1'b1;
    replyTwice = 1'b1;
    repeat (3)
    begin
      d = $urandom_range(60, 8);
      // Partner reads its settings at a rise, so arm it for the next one
      replyDelay = 8'(d);
      wait_en(1'b0, 3000 * TICK, n);
      wait_en(1'b1, 3000 * TICK, n);
      pulse_len(w, l);
      check(w >= d + 2 && w <= d + 9, "completion response");
      check(w + l == code * 100 * TICK, "period after completion");
    end
    replyOn = 1'b0;
    // The running pulse is still answered; move on to an unanswered one
    wait_en(1'b0, 3000 * TICK, n);
    wait_en(1'b1, 3000 * TICK, n);
    manualPinIn = 1'b1;
    pulse_len(w, l);
    check(near(w, width_max(code)), "press");
    manualPinIn = 1'b0;
    // Frozen cycles must not count towards the interval
    clkEn = 1'b0;
    step(20);
    clkEn = 1'b1;
    pulse_len(w, l);
    check(w + l == code * 100 * TICK, "clock enable freeze");
    start(1'b0, 1, 1'b0);
    wait_en(1'b0, 400 * TICK, w);
    check(near(w, width_max(1)), "one-shot width");
    n = 0;
    repeat (800)
    begin
      step(1);
      if (regulatorEnableOut !== 1'b0)
        n++;
    end
    check(n == 0, "one-shot repeated");
    manualPinIn = 1'b1;
    step(10 * TICK);
    manualPinIn = 1'b0;
    n = 0;
    repeat (50 * TICK)
    begin
      step(1);
      if (regulatorEnableOut !== 1'b0)
        n++;
    end
    check(n == 0, "short press accepted");
    replyOn = 1'b1;
    replyTwice = 1'b0;
    replyDelay = 8'h08;
    manualPinIn = 1'b1;
    wait_en(1'b1, 40 * TICK, n);
    check(n >= 20 * TICK - 8 && n <= 30 * TICK + 8, "press response");
    check(measureActive === 1'b0, "reading repeated");
    step(30 * TICK);
    check(regulatorEnableOut === 1'b1, "completion under press");
    manualPinIn = 1'b0;
    wait_en(1'b0, 400 * TICK, w);
    check(w >= width_max(1), "press pulse width");
    complete_run();
  end
endmodule : power_gating_interval_timer_bench
